//--- pss_pkg.sv
// Shared constants and types of the parameter set sequencer
package pss_pkg;

  // Bus and set geometry
  localparam int REG_AW = 5;   // Byte address width of the slave
  localparam int SET_IW = 6;   // Width of a set index
  localparam int CNT_W  = 7;   // Width of the set count
  localparam int MAX_SETS = 64; // Number of stored sets

  // Register byte offsets
  localparam logic [REG_AW-1:0] OFF_CTRL   = 5'h00; // Enable and style
  localparam logic [REG_AW-1:0] OFF_COUNT  = 5'h04; // Available set count
  localparam logic [REG_AW-1:0] OFF_SRC    = 5'h08; // Function pick, origin
  localparam logic [REG_AW-1:0] OFF_SLOT   = 5'h0c; // Slot pointer
  localparam logic [REG_AW-1:0] OFF_CMD    = 5'h10; // Command strobes
  localparam logic [REG_AW-1:0] OFF_ADDR   = 5'h14; // Free address setup
  localparam logic [REG_AW-1:0] OFF_ACTIVE = 5'h18; // Active parameters
  localparam logic [REG_AW-1:0] OFF_STATUS = 5'h1c; // Sequencer state

  // Field positions
  localparam int CTRL_ON   = 0; // sequencer_on
  localparam int CTRL_FREE = 1; // set_progression_style, 1 is free
  localparam int SRC_PICK  = 0; // control_function_pick, 1 is restart
  localparam int SRC_LSB   = 4; // control_trigger_origin, two bits
  localparam int CMD_SAVE  = 0; // save_active_to_slot
  localparam int CMD_COPY  = 1; // copy_slot_to_active
  localparam int CMD_STEP  = 2; // immediate_step_cmd
  localparam int CMD_REWIND = 3; // immediate_rewind_cmd
  localparam int ADDR_B0TWO = 0; // Bit 0 taken from input_pin_two
  localparam int ADDR_INV1 = 1; // Invert input_pin_one
  localparam int ADDR_INV2 = 2; // Invert input_pin_two
  localparam int STAT_WAIT = 8; // Waiting for frame start
  localparam int STAT_ON   = 9; // Sequencer running
  localparam int STAT_BUSY = 10; // Loading or draining

  // Count limits and reset values
  localparam logic [CNT_W-1:0] COUNT_MIN  = 7'h01;
  localparam logic [CNT_W-1:0] COUNT_MAX  = 7'h40;
  localparam logic [CNT_W-1:0] FREE_MAX   = 7'h04;
  localparam logic [CNT_W-1:0] COUNT_RST  = 7'h01;
  localparam logic [31:0]      COUNT_MAX_W = 32'h00000040;

  // Trigger origins
  typedef enum logic [1:0]
  {
    SRC_OFF    = 2'h0,
    SRC_ALWAYS = 2'h1,
    SRC_PIN1   = 2'h2,
    SRC_PIN2   = 2'h3
  } pss_src_t;

  // Sequencer states
  typedef enum logic [4:0]
  {
    ST_OFF   = 5'h01,
    ST_WAIT  = 5'h02,
    ST_FETCH = 5'h04,
    ST_LOAD  = 5'h08,
    ST_DRAIN = 5'h10
  } pss_state_t;

endpackage

//--- pss_mem_if.sv
// Port bundle between the sequencer and its set store
`timescale 1ns/1ps
interface pss_mem_if
#(
  parameter int AW = 6,
  parameter int DW = 16
);
  logic          we;    // Write strobe
  logic [AW-1:0] waddr; // Write slot
  logic [DW-1:0] wdata; // Write word
  logic [AW-1:0] raddr; // Read slot
  logic [DW-1:0] rdata; // Registered read word

  modport ctrl (output we, waddr, wdata, raddr, input rdata);
  modport store (input we, waddr, wdata, raddr, output rdata);
endinterface

//--- pss_mem.sv
// Stored parameter sets with a registered read port
`timescale 1ns/1ps
module pss_mem
#(
  parameter int AW = 6,
  parameter int DW = 16
)
(
  input wire logic sys_clk,
  pss_mem_if.store mem
);
  import pss_pkg::*;

  logic [DW-1:0] cells [0:(1<<AW)-1]; // One word per set
  logic [DW-1:0] rd;                  // Read register

  // Write on strobe, read every cycle; read data lag the address by one
  always_ff @(posedge sys_clk)
  begin
    if (mem.we)
    begin
      cells[mem.waddr] <= mem.wdata;
    end
    rd <= cells[mem.raddr];
  end

  assign mem.rdata = rd;
endmodule

//--- pss_addr.sv
// Forms the free selection address from the two input pins
`timescale 1ns/1ps
module pss_addr
(
  input  wire logic       pin_one,  // input_pin_one level
  input  wire logic       pin_two,  // input_pin_two level
  input  wire logic       b0_two,   // Bit 0 from pin two
  input  wire logic       inv_one,  // Invert pin one
  input  wire logic       inv_two,  // Invert pin two
  input  wire logic       two_bits, // More than two sets
  output logic      [1:0] addr      // Set address
);
  logic l1; // Pin one after inversion
  logic l2; // Pin two after inversion

  // Inversion per pin, then bit mapping
  assign l1 = pin_one ^ inv_one;
  assign l2 = pin_two ^ inv_two;
  // Plain binary; bit 1 forced low with one pin in use
  assign addr[0] = b0_two ? l2 : l1;
  assign addr[1] = two_bits & (b0_two ? l1 : l2);
endmodule

//--- pss_top.sv
// Parameter set sequencer with its Avalon-MM register slave
`timescale 1ns/1ps
// How it works
// - Ordered mode set count capped at 64
// - Function pick routes origin to advance/restart
// - Advance origin: always, pin one, two, none
// - Restart origin: pin one, two, or none
// - No origin: only immediate commands step/rewind
// - Slot pointer spans 0 to usable set count minus one (63 at most)
// - Never saved sets load default values
// - Save copies active word into slot
// - Copy loads slot word into active
// - Free mode: trigger loads pin-addressed set
// - Two pins above two sets, else one
// - Free mode count limited to four
// - Address bit follows pin, optionally inverted
// - Address bits are plain binary set index
// - Turn-off ends frame, restores saved active
// - Triggers ignored while a set loads
module pss_top
#(
  parameter int            DW            = 16,
  parameter logic [DW-1:0] PARAM_DEFAULT = '0
)
(
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  input  wire logic [pss_pkg::REG_AW-1:0]    avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [3:0]                    avs_byteenable,
  input  wire logic [31:0]                   avs_writedata,
  output logic      [31:0]                   avs_readdata,
  output logic                               avs_waitrequest,
  input  wire logic                          input_pin_one,
  input  wire logic                          input_pin_two,
  input  wire logic                          frame_start_trig,
  input  wire logic                          frame_busy,
  output logic      [DW-1:0]                 active_params,
  output logic      [pss_pkg::SET_IW-1:0]    current_set,
  output logic                               waiting_trigger,
  output logic                               frame_go
);
  import pss_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // State record
  typedef struct packed {
    pss_state_t            st;          // Sequencer state
    logic                  on;          // sequencer_on
    logic                  free_mode;   // set_progression_style
    logic [CNT_W-1:0]      count;       // available_set_count
    logic                  pick;        // control_function_pick
    pss_src_t              adv_src;     // Advance origin
    pss_src_t              rst_src;     // Restart origin
    logic [SET_IW-1:0]     slot;        // set_slot_pointer
    logic                  b0_two;      // Bit 0 from pin two
    logic                  inv1;        // Invert pin one
    logic                  inv2;        // Invert pin two
    logic [DW-1:0]         active;      // Active parameter word
    logic [DW-1:0]         backup;      // Word saved at turn-on
    logic                  armed;       // Backup holds a value
    logic [SET_IW-1:0]     cur_set;     // Set now in active
    logic [SET_IW-1:0]     fetch_idx;   // Set being fetched
    logic                  fetch_frame; // Fire frame after load
    logic [MAX_SETS-1:0]   filled;      // Set was saved once
    logic                  pend_step;   // Pending step command
    logic                  pend_rewind; // Pending rewind command
    logic                  ack;         // Bus answer phase
    logic [31:0]           rdata;       // Read data register
    logic                  frame_go;    // Frame start accepted
  } pss_regs_t;

  pss_regs_t r;      // Current state
  pss_regs_t next_r; // Next state

  ////////////////////////////////////////////////////////////////////
  // Helper decode
  logic              req;      // Any bus request
  logic              wr;       // Write in its answer cycle
  logic              wr_lo;    // Write with low lane enabled
  logic              save_cmd; // Save strobe
  logic              copy_cmd; // Copy strobe
  logic              step_cmd; // Step strobe
  logic              rewind_cmd; // Rewind strobe
  logic              idle_ok;  // Commands may run
  logic [CNT_W-1:0]  eff;      // Usable set count
  logic [CNT_W-1:0]  eff_m1;   // Last usable index
  logic [CNT_W-1:0]  cur_p1;   // Current set plus one
  logic [SET_IW-1:0] wrap_idx; // Next set in the cycle
  logic [SET_IW-1:0] free_idx; // Set picked by the pins
  logic [1:0]        pin_addr; // Pin address
  logic              adv_hit;  // Advance origin active
  logic              rst_hit;  // Restart origin active
  logic              trig_ok;  // Trigger taken

  pss_mem_if #(.AW(SET_IW), .DW(DW)) mi ();

  // Usable count; free mode caps it
  function automatic logic [CNT_W-1:0] eff_count
  (
    input logic [CNT_W-1:0] c,
    input logic             f
  );
    eff_count = (f && (c > FREE_MAX)) ? FREE_MAX : c;
  endfunction

  // Register read multiplexer
  function automatic logic [31:0] reg_read
  (
    input logic [REG_AW-1:0] a,
    input pss_regs_t         s
  );
    reg_read = 32'h00000000;
    unique case (a)
      OFF_CTRL:
      begin
        reg_read[CTRL_ON] = s.on;
        reg_read[CTRL_FREE] = s.free_mode;
      end
      OFF_COUNT:  reg_read[CNT_W-1:0] = s.count;
      OFF_SRC:
      begin
        reg_read[SRC_PICK] = s.pick;
        reg_read[SRC_LSB+:2] = s.pick ? s.rst_src : s.adv_src;
      end
      OFF_SLOT:   reg_read[SET_IW-1:0] = s.slot;
      OFF_ADDR:
      begin
        reg_read[ADDR_B0TWO] = s.b0_two;
        reg_read[ADDR_INV1] = s.inv1;
        reg_read[ADDR_INV2] = s.inv2;
      end
      OFF_ACTIVE: reg_read[DW-1:0] = s.active;
      OFF_STATUS:
      begin
        reg_read[SET_IW-1:0] = s.cur_set;
        reg_read[STAT_WAIT] = (s.st == ST_WAIT) & s.on;
        reg_read[STAT_ON] = s.on;
        reg_read[STAT_BUSY] = (s.st != ST_OFF) & (s.st != ST_WAIT);
      end
      default:    reg_read = 32'h00000000;
    endcase
  endfunction

  // Bus handshake: one wait state on every access
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~r.ack;
  assign wr = avs_write & r.ack;
  assign wr_lo = wr & avs_byteenable[0];
  assign save_cmd = wr_lo & (avs_address == OFF_CMD)
                    & avs_writedata[CMD_SAVE];
  assign copy_cmd = wr_lo & (avs_address == OFF_CMD)
                    & avs_writedata[CMD_COPY];
  assign step_cmd = wr_lo & (avs_address == OFF_CMD)
                    & avs_writedata[CMD_STEP];
  assign rewind_cmd = wr_lo & (avs_address == OFF_CMD)
                      & avs_writedata[CMD_REWIND];
  assign idle_ok = (r.st == ST_OFF) | (r.st == ST_WAIT);

  // Cycle arithmetic
  assign eff = eff_count(r.count, r.free_mode);
  assign eff_m1 = eff - COUNT_MIN;
  assign cur_p1 = {1'b0, r.cur_set} + COUNT_MIN;
  assign wrap_idx = (cur_p1 >= eff) ? '0 : cur_p1[SET_IW-1:0];
  assign free_idx = ({5'h00, pin_addr} > eff_m1) ? eff_m1[SET_IW-1:0]
                    : {4'h0, pin_addr};

  // Origin decode for the two functions
  assign adv_hit = (r.adv_src == SRC_ALWAYS)
                   | ((r.adv_src == SRC_PIN1) & input_pin_one)
                   | ((r.adv_src == SRC_PIN2) & input_pin_two);
  assign rst_hit = ((r.rst_src == SRC_PIN1) & input_pin_one)
                   | ((r.rst_src == SRC_PIN2) & input_pin_two);
  // Only the waiting state takes a trigger
  assign trig_ok = frame_start_trig & (r.st == ST_WAIT) & r.on;

  pss_addr u_addr
  (
    .pin_one  (input_pin_one),
    .pin_two  (input_pin_two),
    .b0_two   (r.b0_two),
    .inv_one  (r.inv1),
    .inv_two  (r.inv2),
    .two_bits (eff > 7'h02),
    .addr     (pin_addr)
  );

  pss_mem #(.AW(SET_IW), .DW(DW)) u_mem
  (
    .sys_clk (sys_clk),
    .mem     (mi.store)
  );

  ////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    next_r = r;
    next_r.frame_go = 1'b0;
    next_r.ack = req & ~r.ack;
    mi.we = 1'b0;
    mi.waddr = r.slot;
    mi.wdata = r.active;
    mi.raddr = r.fetch_idx;
    // Read data are sampled in the wait cycle
    if (avs_read & ~r.ack)
    begin
      next_r.rdata = reg_read(avs_address, r);
    end
    // Configuration writes
    if (wr_lo && (avs_address == OFF_CTRL))
    begin
      next_r.on = avs_writedata[CTRL_ON];
      next_r.free_mode = avs_writedata[CTRL_FREE];
    end
    if (wr_lo && (avs_address == OFF_COUNT))
    begin
      if (avs_writedata == 32'h00000000)
        next_r.count = COUNT_MIN;
      else if (avs_writedata > COUNT_MAX_W)
        next_r.count = COUNT_MAX;
      else
        next_r.count = avs_writedata[CNT_W-1:0];
    end
    if (wr_lo && (avs_address == OFF_SRC))
    begin
      next_r.pick = avs_writedata[SRC_PICK];
      // Origin goes to the function just picked
      if (avs_writedata[SRC_PICK])
      begin
        // Restart has no always choice
        next_r.rst_src = (avs_writedata[SRC_LSB+:2] == SRC_ALWAYS)
                         ? SRC_OFF
                         : pss_src_t'(avs_writedata[SRC_LSB+:2]);
      end
      else
      begin
        next_r.adv_src = pss_src_t'(avs_writedata[SRC_LSB+:2]);
      end
    end
    // Out of range pointer values are dropped
    if (wr_lo && (avs_address == OFF_SLOT)
        && (avs_writedata < {25'h0000000, eff}))
    begin
      next_r.slot = avs_writedata[SET_IW-1:0];
    end
    if (wr_lo && (avs_address == OFF_ADDR))
    begin
      next_r.b0_two = avs_writedata[ADDR_B0TWO];
      next_r.inv1 = avs_writedata[ADDR_INV1];
      next_r.inv2 = avs_writedata[ADDR_INV2];
    end
    // Active word honours byte lanes
    if (wr && (avs_address == OFF_ACTIVE))
    begin
      for (int b = 0; b < DW / 8; b++)
      begin
        if (avs_byteenable[b])
          next_r.active[b*8+:8] = avs_writedata[b*8+:8];
      end
    end
    // Immediate commands wait for the waiting state; set beats clear
    next_r.pend_step = r.pend_step | step_cmd;
    next_r.pend_rewind = r.pend_rewind | rewind_cmd;
    // Save writes the active word into the pointed slot
    if (save_cmd && idle_ok)
    begin
      mi.we = 1'b1;
      next_r.filled[r.slot] = 1'b1;
    end
    unique case (r.st)
      // Idle: wait for turn-on or a copy
      ST_OFF:
      begin
        if (r.on)
        begin
          next_r.backup = r.active;
          next_r.armed = 1'b1;
          next_r.fetch_idx = '0;
          next_r.fetch_frame = 1'b0;
          next_r.pend_step = step_cmd;
          next_r.pend_rewind = rewind_cmd;
          next_r.st = r.free_mode ? ST_WAIT : ST_FETCH;
        end
        else if (copy_cmd)
        begin
          next_r.fetch_idx = r.slot;
          next_r.fetch_frame = 1'b0;
          next_r.st = ST_FETCH;
        end
      end
      // Running and waiting for a frame start
      ST_WAIT:
      begin
        next_r.fetch_frame = 1'b0;
        if (!r.on)
        begin
          next_r.st = ST_DRAIN;
        end
        else if (copy_cmd)
        begin
          next_r.fetch_idx = r.slot;
          next_r.st = ST_FETCH;
        end
        else if (trig_ok && r.free_mode)
        begin
          next_r.fetch_idx = free_idx;
          next_r.fetch_frame = 1'b1;
          next_r.st = ST_FETCH;
        end
        else if (trig_ok)
        begin
          // Frame uses the set now active, then moves on if an origin hits
          next_r.frame_go = 1'b1;
          if (rst_hit)
          begin
            next_r.fetch_idx = '0;
            next_r.st = ST_FETCH;
          end
          else if (adv_hit)
          begin
            next_r.fetch_idx = wrap_idx;
            next_r.st = ST_FETCH;
          end
        end
        else if (r.pend_rewind && !r.free_mode)
        begin
          next_r.pend_rewind = rewind_cmd;
          next_r.fetch_idx = '0;
          next_r.st = ST_FETCH;
        end
        else if (r.pend_step && !r.free_mode)
        begin
          next_r.pend_step = step_cmd;
          next_r.fetch_idx = wrap_idx;
          next_r.st = ST_FETCH;
        end
      end
      // Read address issued, data next cycle
      ST_FETCH:
      begin
        next_r.st = ST_LOAD;
      end
      // Unsaved sets give the default word
      ST_LOAD:
      begin
        next_r.active = r.filled[r.fetch_idx] ? mi.rdata
                        : PARAM_DEFAULT;
        next_r.cur_set = r.fetch_idx;
        next_r.frame_go = r.fetch_frame;
        if (r.on)
          next_r.st = ST_WAIT;
        else
          next_r.st = r.armed ? ST_DRAIN : ST_OFF;
      end
      // Let the frame finish, then put the old word back
      ST_DRAIN:
      begin
        if (!frame_busy)
        begin
          next_r.active = r.backup;
          next_r.armed = 1'b0;
          next_r.st = ST_OFF;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      r <= '0;
      r.st <= ST_OFF;
      r.count <= COUNT_RST;
      r.adv_src <= SRC_OFF;
      r.rst_src <= SRC_OFF;
      r.active <= PARAM_DEFAULT;
      r.backup <= PARAM_DEFAULT;
    end
    else
    begin
      r <= next_r;
    end
  end

  // Outputs
  assign avs_readdata = r.rdata;
  assign active_params = r.active;
  assign current_set = r.cur_set;
  assign waiting_trigger = (r.st == ST_WAIT) & r.on;
  assign frame_go = r.frame_go;

  ////////////////////////////////////////////////////////////////////
  // Checks
  a_count_cap: assert property (@(posedge sys_clk) disable iff (rst)
    (r.count >= COUNT_MIN) && (r.count <= COUNT_MAX))
    else $error("set count out of range");
  a_free_cap: assert property (@(posedge sys_clk) disable iff (rst)
    r.free_mode |-> (eff <= FREE_MAX))
    else $error("free mode count above four");
  a_restart_zero: assert property (@(posedge sys_clk) disable iff (rst)
    (trig_ok && !r.free_mode && rst_hit && !copy_cmd)
    |=> (r.st == ST_FETCH) && (r.fetch_idx == '0) && r.frame_go)
    else $error("restart did not fetch set zero");
  a_advance_wrap: assert property (@(posedge sys_clk) disable iff (rst)
    (trig_ok && !r.free_mode && !rst_hit && adv_hit && !copy_cmd)
    |=> (r.fetch_idx == $past(wrap_idx))
    ##2 (r.cur_set == $past(wrap_idx, 3)))
    else $error("advance went to wrong set");
  a_step_async: assert property (@(posedge sys_clk) disable iff (rst)
    (r.st == ST_WAIT && r.on && !r.free_mode && !frame_start_trig
     && !copy_cmd && !r.pend_rewind && r.pend_step)
    |=> (r.st == ST_FETCH) ##2 (r.st == ST_WAIT || !r.on))
    else $error("pending step not executed");
  a_save_slot: assert property (@(posedge sys_clk) disable iff (rst)
    (save_cmd && idle_ok) |-> mi.we && (mi.waddr == r.slot)
    && (mi.wdata == r.active) ##1 r.filled[$past(r.slot)])
    else $error("save did not write slot");
  a_load_word: assert property (@(posedge sys_clk)
    disable iff (rst)
    (r.st == ST_LOAD) |=> r.active == ($past(r.filled[r.fetch_idx])
    ? $past(mi.rdata) : PARAM_DEFAULT))
    else $error("loaded word wrong");
  a_free_pick: assert property (@(posedge sys_clk) disable iff (rst)
    (trig_ok && r.free_mode && !copy_cmd)
    |=> (r.fetch_idx == $past(free_idx)) ##2 frame_go)
    else $error("free selection failed");
  a_pin_binary: assert property (@(posedge sys_clk) disable iff (rst)
    (!r.b0_two) |-> pin_addr[0] == (input_pin_one ^ r.inv1)
    && (pin_addr[1] == ((eff > 7'h02) & (input_pin_two ^ r.inv2))))
    else $error("pin address mismatch");
  a_trig_ignored: assert property (@(posedge sys_clk)
    disable iff (rst)
    (r.st == ST_FETCH) |-> !waiting_trigger ##1 !trig_ok)
    else $error("trigger taken during load");
  a_restore_old: assert property (@(posedge sys_clk) disable iff (rst)
    (r.st == ST_DRAIN && !frame_busy)
    |=> (r.active == $past(r.backup)) && (r.st == ST_OFF))
    else $error("turn-off did not restore");
  a_slot_bound: assert property (@(posedge sys_clk) disable iff (rst)
    (r.slot != $past(r.slot)) |-> ({1'b0, r.slot} < $past(eff)))
    else $error("slot beyond count");
endmodule

//--- pss_far.sv
// Far-side model: external input lines and frame activity
`timescale 1ns/1ps
module pss_far
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       frame_go,
  input  wire logic [1:0] want,
  output logic            pin_one,
  output logic            pin_two,
  output logic            frame_busy
);
  logic [2:0] left; // Frame cycles still to run

  // Lines follow the wanted levels; each frame keeps busy for 4 cycles
  always_ff @(posedge sys_clk)
  begin
    pin_one <= want[0];
    pin_two <= want[1];
    if (rst)
      left <= 3'h0;
    else if (frame_go)
      left <= 3'h4;
    else if (left != 3'h0)
      left <= left - 3'h1;
  end
  assign frame_busy = (left != 3'h0);
endmodule

//--- test_pss_top.sv
// Self-checking testbench of the parameter set sequencer
`timescale 1ns/1ps
module test_pss_top;
  import pss_pkg::*;
  logic        sys_clk = 1'b0;      // 20 MHz clock
  logic        rst = 1'b1;          // Synchronous reset
  logic [4:0]  avs_address = 5'h00; // Bus request fields
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        pin_one, pin_two, frame_busy, waiting_trigger, frame_go;
  logic        trig = 1'b0;         // Frame start pulse
  logic [1:0]  want = 2'h0;         // Wanted line levels
  logic [15:0] active_params;
  logic [5:0]  current_set;
  logic [31:0] rv;                  // Last read word
  int          n_fail = 0, n_checks = 0, cyc = 0;

  always #25 sys_clk = ~sys_clk;

  pss_top uut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hf),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .input_pin_one(pin_one),
    .input_pin_two(pin_two), .frame_start_trig(trig),
    .frame_busy(frame_busy), .active_params(active_params),
    .current_set(current_set), .waiting_trigger(waiting_trigger),
    .frame_go(frame_go));
  pss_far far (.sys_clk(sys_clk), .rst(rst), .frame_go(frame_go),
    .want(want), .pin_one(pin_one), .pin_two(pin_two),
    .frame_busy(frame_busy));

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Compares one value and counts it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    // Waitrequest is looked at settled, ahead of the edge that ends it
    do
    begin
      @(negedge sys_clk);
    end
    while (avs_waitrequest !== 1'b0);
    rv = avs_readdata;
    @(posedge sys_clk);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Reads a register and compares the masked word
  task automatic rchk(input logic [4:0] a, input logic [31:0] e,
                      input logic [31:0] m);
    bus(1'b0, a, 32'h0);
    chk(rv & m, e);
  endtask

  // Triggers once waiting, then checks the set and word of that frame
  task automatic fire(input logic [5:0] s, input logic [15:0] p);
    repeat (4) @(negedge sys_clk);
    while (waiting_trigger !== 1'b1)
    begin
      @(negedge sys_clk);
    end
    @(posedge sys_clk);
    trig <= 1'b1;
    @(posedge sys_clk);
    trig <= 1'b0;
    // Frame pulse is looked at mid-cycle, while it stands
    do
    begin
      @(negedge sys_clk);
    end
    while (frame_go !== 1'b1);
    chk({26'h0, current_set}, {26'h0, s});
    chk({16'h0, active_params}, {16'h0, p});
  endtask

  // Lines settle for a microsecond before the trigger
  task automatic pick(input logic [1:0] w, input logic [5:0] s,
                      input logic [15:0] p);
    want <= w;
    repeat (20) @(posedge sys_clk);
    fire(s, p);
  endtask

  // Reconfigures free selection with the sequencer off, then turns it on
  task automatic free_on(input logic [31:0] ad, input logic [31:0] c);
    bus(1'b1, OFF_CTRL, 32'h2);
    bus(1'b1, OFF_COUNT, c);
    bus(1'b1, OFF_ADDR, ad);
    bus(1'b1, OFF_CTRL, 32'h3);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      final_report();
    end
  end

  // Main sequence
  initial
  begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    rchk(OFF_COUNT, 32'h1, 32'h7f);
    bus(1'b1, OFF_COUNT, 32'h50);
    rchk(OFF_COUNT, 32'h40, 32'h7f);
    rchk(5'h02, 32'h0, 32'hffffffff);
    bus(1'b1, OFF_SRC, 32'h10);
    rchk(OFF_SRC, 32'h10, 32'h30);
    bus(1'b1, OFF_SRC, 32'h31);
    rchk(OFF_SRC, 32'h30, 32'h30);
    bus(1'b1, OFF_SRC, 32'h11);
    rchk(OFF_SRC, 32'h0, 32'h30);
    bus(1'b1, OFF_SRC, 32'h0);
    bus(1'b1, OFF_COUNT, 32'h4);
    // Fill slots 0, 1 and 3; slot 2 stays unfilled
    for (int i = 0; i < 4; i++)
    begin
      if (i != 2)
      begin
        bus(1'b1, OFF_ACTIVE, 32'ha0 + 32'(i));
        bus(1'b1, OFF_SLOT, 32'(i));
        bus(1'b1, OFF_CMD, 32'h1);
      end
    end
    bus(1'b1, OFF_SLOT, 32'h1);
    bus(1'b1, OFF_ACTIVE, 32'h0);
    bus(1'b1, OFF_CMD, 32'h2);
    repeat (4) @(posedge sys_clk);
    rchk(OFF_ACTIVE, 32'ha1, 32'hffff);
    bus(1'b1, OFF_SLOT, 32'h2);
    bus(1'b1, OFF_CMD, 32'h2);
    repeat (4) @(posedge sys_clk);
    rchk(OFF_ACTIVE, 32'h0, 32'hffff);
    bus(1'b1, OFF_SLOT, 32'h5);
    rchk(OFF_SLOT, 32'h2, 32'h3f);
    bus(1'b1, OFF_SLOT, 32'h3);
    rchk(OFF_SLOT, 32'h3, 32'h3f);
    // Ordered mode with no origin: only commands move the set
    bus(1'b1, OFF_ACTIVE, 32'h5555);
    bus(1'b1, OFF_CTRL, 32'h1);
    fire(6'h0, 16'ha0);
    fire(6'h0, 16'ha0);
    bus(1'b1, OFF_CMD, 32'h4);
    fire(6'h1, 16'ha1);
    bus(1'b1, OFF_CMD, 32'h8);
    fire(6'h0, 16'ha0);
    bus(1'b1, OFF_CTRL, 32'h0);
    repeat (8) @(posedge sys_clk);
    rchk(OFF_ACTIVE, 32'h5555, 32'hffff);
    // Free selection: lines address the set
    free_on(32'h0, 32'h4);
    for (int k = 0; k < 4; k++)
      pick(2'(k), 6'(k), (k == 2) ? 16'h0 : 16'ha0 + 16'(k));
    free_on(32'h6, 32'h4);
    pick(2'h1, 6'h2, 16'h0);
    free_on(32'h1, 32'h4);
    pick(2'h2, 6'h1, 16'ha1);
    bus(1'b1, OFF_CTRL, 32'h2);
    bus(1'b1, OFF_COUNT, 32'h8);
    rchk(OFF_COUNT, 32'h8, 32'h7f);
    bus(1'b1, OFF_SLOT, 32'h4);
    rchk(OFF_SLOT, 32'h3, 32'h3f);
    free_on(32'h0, 32'h2);
    pick(2'h3, 6'h1, 16'ha1);
    // Ordered mode with origins: always advances, pin one restarts
    bus(1'b1, OFF_CTRL, 32'h0);
    bus(1'b1, OFF_COUNT, 32'h4);
    bus(1'b1, OFF_SRC, 32'h10);
    bus(1'b1, OFF_SRC, 32'h21);
    want <= 2'h0;
    bus(1'b1, OFF_CTRL, 32'h1);
    fire(6'h0, 16'ha0);
    fire(6'h1, 16'ha1);
    want <= 2'h1;
    fire(6'h2, 16'h0);
    fire(6'h0, 16'ha0);
    final_report();
  end
endmodule
